// ==== core/updown_reload_clockout_timer.sv ====
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - count is two cascaded bytes; low byte carry advances high byte
// - source select clear counts divided clock, set counts pin events
// - counter advances only while run_control is set, else holds
// - capture, auto-reload or baud mode from the three select bits
// - up/down enabled in auto-reload: direction input level sets direction
// - counting up wraps at FFFFh, sets overflow flag outside baud and clock-out modes, loads reload value (0000h in capture mode)
// - counting down wraps when count equals reload, loads FFFFh, sets flag outside clock-out mode
// - in up/down mode external flag toggles on each wrap, no interrupt
// - clock-out drives timer pin with square wave toggling on overflow
// - in clock-out mode low byte increments at half peripheral clock
// - in clock-out mode outside capture mode each up overflow reloads count from reload bytes
// - clock-out overflows raise no interrupt request
// - clock-out rate is clock over four times (65536 minus reload)
// - baud generation and clock-out share the same reload bytes
// - trigger enabled outside up/down mode: direction input falling edge captures or reloads, in baud mode only sets external flag and external interrupt status
// - baud selects force auto-reload and ignore capture select
module updown_reload_clockout_timer
  import timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       timer_pin_i,
  input  wire logic       direction_ext_input,
  output logic      [7:0] rdata,
  output logic            irq,
  output logic            timer_pin_o,
  output logic            timer_pin_oe,
  output logic            baud_tick
);

  control_t    ctrl_r,        ctrl_nxt;
  mode_t       mode_r,        mode_nxt;
  logic [7:0]  timer_low_byte_r,  timer_low_byte_nxt;
  logic [7:0]  timer_high_byte_r, timer_high_byte_nxt;
  logic [7:0]  reload_low_byte_r,  reload_low_byte_nxt;
  logic [7:0]  reload_high_byte_r, reload_high_byte_nxt;
  irq_bits_t   status_r,      status_nxt;
  irq_bits_t   mask_r,        mask_nxt;
  logic [3:0]  pre_r,         pre_nxt;
  logic        half_r,        half_nxt;
  logic        clkout_r,      clkout_nxt;
  logic        oe_r,          oe_nxt;
  logic        baud_r,        baud_nxt;
  logic        irq_r,         irq_nxt;
  logic [7:0]  rdata_r,       rdata_nxt;

  pin_events_t pin;
  logic [15:0] count;
  logic [15:0] reload;
  logic        baud_mode;
  logic        capture_mode;
  logic        updown_active;
  logic        fast_rate;
  logic        tick;
  logic        count_down;
  logic        wrap_up;
  logic        wrap_dn;
  logic        wrap;
  logic        ext_hit;
  logic        ovf_set;
  logic        carry;
  logic [7:0]  low_step;
  logic [7:0]  high_step;

  pin_sync pin_sync_inst (
    .clk                 (clk),
    .resetn              (resetn),
    .timer_pin_i         (timer_pin_i),
    .direction_ext_input (direction_ext_input),
    .events              (pin)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  assign count  = {timer_high_byte_r, timer_low_byte_r};
  assign reload = {reload_high_byte_r, reload_low_byte_r};

  // mode decode
  always_comb begin
    baud_mode     = ctrl_r.receive_clock_select
                  | ctrl_r.transmit_clock_select;
    capture_mode  = ctrl_r.capture_reload_select & ~baud_mode;
    updown_active = mode_r.updown_enable & ~capture_mode
                  & ~baud_mode;
    fast_rate     = mode_r.clock_out_enable | baud_mode;
  end

  // prescaler is free running so the first tick spacing depends on its phase at start
  always_comb begin
    pre_nxt  = (pre_r == PRESCALE_LAST) ? 4'h0 : pre_r + 4'h1;
    half_nxt = ~half_r;
    tick     = ctrl_r.run_control
             & (ctrl_r.count_source_select ? pin.count_fall
               : (fast_rate ? half_r
                 : (pre_r == PRESCALE_LAST)));
  end

  // count datapath
  always_comb begin
    count_down = updown_active & ~pin.dir_level;
    wrap_up    = tick & ~count_down & (count == COUNT_TOP);
    wrap_dn    = tick & count_down & (count == reload);
    wrap       = wrap_up | wrap_dn;
    ext_hit    = pin.dir_fall & ctrl_r.ext_trigger_enable
               & ~updown_active;
    ovf_set    = wrap & ~baud_mode & ~mode_r.clock_out_enable;
    carry      = count_down ? (timer_low_byte_r == BYTE_ZERO)
                            : (timer_low_byte_r == BYTE_TOP);
    low_step   = count_down ? timer_low_byte_r - 8'h01
                            : timer_low_byte_r + 8'h01;
    high_step  = count_down ? timer_high_byte_r - {7'h00, carry}
                            : timer_high_byte_r + {7'h00, carry};

    timer_low_byte_nxt   = timer_low_byte_r;
    timer_high_byte_nxt  = timer_high_byte_r;
    reload_low_byte_nxt  = reload_low_byte_r;
    reload_high_byte_nxt = reload_high_byte_r;

    if (wrap_dn) begin
      {timer_high_byte_nxt, timer_low_byte_nxt} = COUNT_TOP;
    end else if (wrap_up) begin
      // capture mode rolls over; all other modes reload
      {timer_high_byte_nxt, timer_low_byte_nxt} =
        capture_mode ? COUNT_RESET : reload;
    end else if (tick) begin
      timer_low_byte_nxt  = low_step;
      timer_high_byte_nxt = high_step;
    end

    if (ext_hit && capture_mode) begin
      {reload_high_byte_nxt, reload_low_byte_nxt} = count;
    end else if (ext_hit && !baud_mode) begin
      {timer_high_byte_nxt, timer_low_byte_nxt} = reload;
    end

    // a software write to a byte wins over the counter that cycle
    if (wr && hit(addr, ADDR_TIMER_LOW))   timer_low_byte_nxt   = wdata;
    if (wr && hit(addr, ADDR_TIMER_HIGH))  timer_high_byte_nxt  = wdata;
    if (wr && hit(addr, ADDR_RELOAD_LOW))  reload_low_byte_nxt  = wdata;
    if (wr && hit(addr, ADDR_RELOAD_HIGH)) reload_high_byte_nxt = wdata;
  end

  // control flags: hardware set wins over a software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    mode_nxt = mode_r;
    if (wr && hit(addr, ADDR_CONTROL)) ctrl_nxt = control_t'(wdata);
    if (wr && hit(addr, ADDR_MODE))    mode_nxt = mode_t'(wdata[1:0]);
    if (ovf_set) ctrl_nxt.overflow_flag = 1'b1;
    if (wrap && updown_active) begin
      ctrl_nxt.external_flag = ~ctrl_r.external_flag;
    end
    if (ext_hit) ctrl_nxt.external_flag = 1'b1;
  end

  // interrupt status, read clears, event in same cycle survives
  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (rd && hit(addr, ADDR_IRQ_STATUS)) status_nxt = IRQ_RESET;
    if (wr && hit(addr, ADDR_IRQ_MASK))   mask_nxt   = irq_bits_t'(wdata[1:0]);
    if (ovf_set) status_nxt.ovf_event = 1'b1;
    if (ext_hit) status_nxt.ext_event = 1'b1;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // pin and baud outputs; baud and clock-out share the reload bytes
  always_comb begin
    clkout_nxt = clkout_r;
    if (wrap && mode_r.clock_out_enable) clkout_nxt = ~clkout_r;
    oe_nxt   = mode_r.clock_out_enable;
    baud_nxt = wrap & baud_mode;
  end

  // register read mux; data valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_CONTROL:     rdata_nxt = ctrl_r;
        ADDR_MODE:        rdata_nxt = {6'h00, mode_r};
        ADDR_TIMER_LOW:   rdata_nxt = timer_low_byte_r;
        ADDR_TIMER_HIGH:  rdata_nxt = timer_high_byte_r;
        ADDR_RELOAD_LOW:  rdata_nxt = reload_low_byte_r;
        ADDR_RELOAD_HIGH: rdata_nxt = reload_high_byte_r;
        ADDR_IRQ_STATUS:  rdata_nxt = {6'h00, status_r};
        ADDR_IRQ_MASK:    rdata_nxt = {6'h00, mask_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r             <= control_t'(CONTROL_RESET);
      mode_r             <= mode_t'(MODE_RESET);
      timer_low_byte_r   <= BYTE_RESET;
      timer_high_byte_r  <= BYTE_RESET;
      reload_low_byte_r  <= BYTE_RESET;
      reload_high_byte_r <= BYTE_RESET;
      status_r           <= irq_bits_t'(IRQ_RESET);
      mask_r             <= irq_bits_t'(IRQ_RESET);
      pre_r              <= 4'h0;
      half_r             <= 1'b0;
      clkout_r           <= 1'b0;
      oe_r               <= 1'b0;
      baud_r             <= 1'b0;
      irq_r              <= 1'b0;
      rdata_r            <= 8'h00;
    end else begin
      ctrl_r             <= ctrl_nxt;
      mode_r             <= mode_nxt;
      timer_low_byte_r   <= timer_low_byte_nxt;
      timer_high_byte_r  <= timer_high_byte_nxt;
      reload_low_byte_r  <= reload_low_byte_nxt;
      reload_high_byte_r <= reload_high_byte_nxt;
      status_r           <= status_nxt;
      mask_r             <= mask_nxt;
      pre_r              <= pre_nxt;
      half_r             <= half_nxt;
      clkout_r           <= clkout_nxt;
      oe_r               <= oe_nxt;
      baud_r             <= baud_nxt;
      irq_r              <= irq_nxt;
      rdata_r            <= rdata_nxt;
    end
  end

  assign rdata        = rdata_r;
  assign irq          = irq_r;
  assign timer_pin_o  = clkout_r;
  assign timer_pin_oe = oe_r;
  assign baud_tick    = baud_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !wr && !ext_hit;

  sequence clkout_wrap;
    wrap && mode_r.clock_out_enable && !wr;
  endsequence

  sequence updown_wrap;
    wrap && updown_active && !wr && !ext_hit;
  endsequence

  AST_HOLD: assert property (
    !ctrl_r.run_control && quiet |=> $stable(count))
    else $error("count moved while stopped");

  AST_CARRY: assert property (
    tick && !count_down && timer_low_byte_r == BYTE_TOP
    && count != COUNT_TOP && quiet
    |=> timer_high_byte_r == $past(timer_high_byte_r) + 8'h01
        && timer_low_byte_r == BYTE_ZERO)
    else $error("low byte carry did not advance high byte");

  AST_UP_WRAP: assert property (
    wrap_up && !capture_mode && !baud_mode
    && !mode_r.clock_out_enable && quiet
    |=> count == $past(reload) && ctrl_r.overflow_flag)
    else $error("up wrap did not reload and flag");

  AST_DOWN_WRAP: assert property (
    wrap_dn && quiet |=> count == COUNT_TOP && ctrl_r.overflow_flag)
    else $error("down wrap did not load top and flag");

  AST_EXT_TOGGLE: assert property (
    updown_wrap |=> ctrl_r.external_flag != $past(ctrl_r.external_flag)
                    && !(status_r.ext_event && !$past(status_r.ext_event)))
    else $error("external flag did not toggle quietly");

  AST_CLKOUT_PIN: assert property (
    clkout_wrap |=> timer_pin_o != $past(timer_pin_o)
                    ##1 timer_pin_oe)
    else $error("clock-out pin did not toggle on wrap");

  AST_CLKOUT_RATE: assert property (
    mode_r.clock_out_enable && !ctrl_r.count_source_select
    && ctrl_r.run_control && tick
    && !(wr && hit(addr, ADDR_CONTROL)) |=> !tick)
    else $error("clock-out counted faster than half rate");

  AST_CLKOUT_NOIRQ: assert property (
    clkout_wrap and (!ctrl_r.overflow_flag && !baud_mode && !ext_hit)
    |=> !ctrl_r.overflow_flag && !status_r.ovf_event)
    else $error("clock-out wrap raised a request");

  AST_CAPTURE: assert property (
    ext_hit && capture_mode && !wr
    |=> reload == $past(count) && ctrl_r.external_flag)
    else $error("capture edge did not latch count");

  AST_IRQ: assert property (
    status_r.ext_event && mask_r.ext_event
    && !(rd && hit(addr, ADDR_IRQ_STATUS)) |=> irq)
    else $error("masked-in status did not raise interrupt");

endmodule : updown_reload_clockout_timer

// ==== inc/timer_pkg.sv ====
package timer_pkg;

  // register index on the plain register port
  localparam logic [3:0] ADDR_CONTROL     = 4'h0;
  localparam logic [3:0] ADDR_MODE        = 4'h1;
  localparam logic [3:0] ADDR_TIMER_LOW   = 4'h2;
  localparam logic [3:0] ADDR_TIMER_HIGH  = 4'h3;
  localparam logic [3:0] ADDR_RELOAD_LOW  = 4'h4;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h7;

  // values after reset, and count and byte limits
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_TOP     = 16'hFFFF;
  localparam logic [7:0]  BYTE_TOP      = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // rates: internal timer clock is the peripheral clock over 12,
  // clock-out and baud modes count at the peripheral clock over 2
  localparam int         PERIPH_CLK_HZ  = 100_000_000;
  localparam logic [3:0] PRESCALE_LAST  = 4'hB;

  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic ext_trigger_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } control_t;

  typedef struct packed {
    logic updown_enable;
    logic clock_out_enable;
  } mode_t;

  typedef struct packed {
    logic ext_event;
    logic ovf_event;
  } irq_bits_t;

  typedef struct packed {
    logic count_fall;
    logic dir_level;
    logic dir_fall;
  } pin_events_t;

endpackage : timer_pkg

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import timer_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  timer_pin_i,
  input  wire logic  direction_ext_input,
  output pin_events_t events
);

  logic [1:0] meta_r;
  logic [1:0] meta_nxt;
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;
  logic [1:0] last_r;
  logic [1:0] last_nxt;

  // bit 1 count pin, bit 0 direction pin; meta feeds only sync
  always_comb begin
    meta_nxt = {timer_pin_i, direction_ext_input};
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      last_r <= 2'h3;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  always_comb begin
    events.count_fall = last_r[1] & ~sync_r[1];
    events.dir_level  = sync_r[0];
    events.dir_fall   = last_r[0] & ~sync_r[0];
  end

endmodule : pin_sync

// ==== sim/ext_pins.sv ====
`timescale 1ns/1ps
module ext_pins (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pulse_go,
  input  wire logic dir_cmd,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_level,
  output logic      dir_level
);
  logic [2:0] low_cnt_r;

  // one low pulse of four cycles; idle high so no false falling edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_cnt_r <= 3'h0;
    else if (pulse_go) low_cnt_r <= 3'h4;
    else if (low_cnt_r != 3'h0) low_cnt_r <= low_cnt_r - 3'h1;
  end

  // the device wins the shared pin while it drives it
  assign pin_level = pin_oe ? pin_o : (low_cnt_r == 3'h0);
  assign dir_level = dir_cmd;
endmodule : ext_pins

// ==== sim/updown_reload_clockout_timer_tb.sv ====
`timescale 1ns/1ps
module updown_reload_clockout_timer_tb;
  import timer_pkg::*;
  localparam logic [15:0] CO_RELOAD = 16'hFFFC;
  localparam int          HALF_GAP  = 2 * (65536 - int'(CO_RELOAD));
  localparam int          WATCH_LEN = 80;
  logic       clk, resetn, wr, rd, pulse_go, dir_cmd, pin_lvl, dir_lvl;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic       irq, timer_pin_o, timer_pin_oe, baud_tick, rd_q, pin_q, watch;
  logic [7:0] exp_q[$];
  logic [15:0] seed, v;
  int         fails, compares, cyc, pin_cnt, baud_cnt, pin_seen, baud_seen;

  updown_reload_clockout_timer updown_reload_clockout_timer_inst (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .timer_pin_i(pin_lvl), .direction_ext_input(dir_lvl),
    .rdata(rdata), .irq(irq), .timer_pin_o(timer_pin_o),
    .timer_pin_oe(timer_pin_oe), .baud_tick(baud_tick));
  ext_pins ext_pins_inst (
    .clk(clk), .resetn(resetn), .pulse_go(pulse_go), .dir_cmd(dir_cmd),
    .pin_o(timer_pin_o), .pin_oe(timer_pin_oe), .pin_level(pin_lvl),
    .dir_level(dir_lvl));

  always #5 clk = ~clk;

  function automatic logic [15:0] xs(input logic [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction : xs

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) pulse_go <= 1'b1;
      @(posedge clk) pulse_go <= 1'b0;
      wait_n(8);
    end
  endtask : pulses

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    pin_q <= timer_pin_o;
    pin_cnt <= (timer_pin_o !== pin_q) ? 1 : pin_cnt + 1;
    baud_cnt <= baud_tick ? 1 : baud_cnt + 1;
    if (watch && timer_pin_o !== pin_q) begin
      pin_seen <= pin_seen + 1;
      chk("pin_gap", 16'(HALF_GAP), 16'(pin_cnt));
    end
    if (watch && baud_tick) begin
      baud_seen <= baud_seen + 1;
      chk("baud_gap", 16'(HALF_GAP), 16'(baud_cnt));
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    clk = 0; resetn = 0; wr = 0; rd = 0; addr = 0; wdata = 0; watch = 0;
    pulse_go = 0; dir_cmd = 1; fails = 0; compares = 0; cyc = 0;
    pin_cnt = 0; baud_cnt = 0; pin_seen = 0; baud_seen = 0; seed = 16'h0AF3;
    wait_n(6);
    resetn <= 1'b1;
    for (int a = 0; a < 9; a++) rd_reg(4'(a), BYTE_RESET);
    repeat (4) begin
      seed = xs(seed);
      v = seed;
      wr_reg(ADDR_RELOAD_LOW, v[7:0]);
      wr_reg(ADDR_RELOAD_HIGH, v[15:8]);
      wr_reg(ADDR_TIMER_LOW, v[15:8]);
      wr_reg(ADDR_TIMER_HIGH, v[7:0]);
      rd_reg(ADDR_RELOAD_LOW, v[7:0]);
      rd_reg(ADDR_RELOAD_HIGH, v[15:8]);
      rd_reg(ADDR_TIMER_LOW, v[15:8]);
      rd_reg(ADDR_TIMER_HIGH, v[7:0]);
    end
    // up count through the top: overflow reloads and raises the flag
    wr_reg(ADDR_MODE, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h06);
    wr_reg(ADDR_TIMER_LOW, 8'hFE);
    wr_reg(ADDR_TIMER_HIGH, 8'hFF);
    wr_reg(ADDR_RELOAD_LOW, 8'h34);
    wr_reg(ADDR_RELOAD_HIGH, 8'h12);
    pulses(2);
    rd_reg(ADDR_CONTROL, 8'hC6);
    wait_n(2);
    chk("irq_masked", 16'h0, {15'h0, irq});
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    wait_n(2);
    chk("irq_on", 16'h1, {15'h0, irq});
    rd_reg(ADDR_IRQ_STATUS, 8'h01);
    wait_n(2);
    chk("irq_off", 16'h0, {15'h0, irq});
    rd_reg(ADDR_TIMER_LOW, 8'h34);
    rd_reg(ADDR_TIMER_HIGH, 8'h12);
    // down count: matching the reload value wraps to the top
    wr_reg(ADDR_CONTROL, 8'h06);
    dir_cmd <= 1'b0;
    wr_reg(ADDR_TIMER_LOW, 8'h35);
    wr_reg(ADDR_TIMER_HIGH, 8'h12);
    pulses(2);
    rd_reg(ADDR_TIMER_LOW, 8'hFF);
    rd_reg(ADDR_TIMER_HIGH, 8'hFF);
    rd_reg(ADDR_CONTROL, 8'hC6);
    rd_reg(ADDR_IRQ_STATUS, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h02);
    pulses(2);
    rd_reg(ADDR_TIMER_LOW, 8'hFF);
    rd_reg(ADDR_TIMER_HIGH, 8'hFF);
    // trigger edge reloads, then captures
    wr_reg(ADDR_MODE, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h0E);
    dir_cmd <= 1'b1;
    wr_reg(ADDR_TIMER_LOW, 8'h55);
    wr_reg(ADDR_TIMER_HIGH, 8'h55);
    wr_reg(ADDR_RELOAD_LOW, 8'hCD);
    wr_reg(ADDR_RELOAD_HIGH, 8'hAB);
    dir_cmd <= 1'b0;
    wait_n(8);
    rd_reg(ADDR_TIMER_LOW, 8'hCD);
    rd_reg(ADDR_TIMER_HIGH, 8'hAB);
    rd_reg(ADDR_CONTROL, 8'h4E);
    chk("irq_ext_masked", 16'h0, {15'h0, irq});
    wr_reg(ADDR_IRQ_MASK, 8'h03);
    wait_n(2);
    chk("irq_ext", 16'h1, {15'h0, irq});
    rd_reg(ADDR_IRQ_STATUS, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h0F);
    dir_cmd <= 1'b1;
    wr_reg(ADDR_TIMER_LOW, 8'h78);
    wr_reg(ADDR_TIMER_HIGH, 8'h56);
    dir_cmd <= 1'b0;
    wait_n(8);
    rd_reg(ADDR_RELOAD_LOW, 8'h78);
    rd_reg(ADDR_RELOAD_HIGH, 8'h56);
    rd_reg(ADDR_IRQ_STATUS, 8'h02);
    // clock-out and baud together, set up in the required order
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_MODE, 8'h01);
    wr_reg(ADDR_RELOAD_LOW, CO_RELOAD[7:0]);
    wr_reg(ADDR_RELOAD_HIGH, CO_RELOAD[15:8]);
    wr_reg(ADDR_TIMER_LOW, CO_RELOAD[7:0]);
    wr_reg(ADDR_TIMER_HIGH, CO_RELOAD[15:8]);
    wr_reg(ADDR_CONTROL, 8'h14);
    wait_n(40);
    watch <= 1'b1;
    wait_n(WATCH_LEN);
    watch <= 1'b0;
    wait_n(2);
    // a dead clock-out would otherwise leave the gap checks silent
    chk("pin_edges", 16'(WATCH_LEN / HALF_GAP), 16'(pin_seen));
    chk("baud_ticks", 16'(WATCH_LEN / HALF_GAP), 16'(baud_seen));
    chk("pin_oe", 16'h1, {15'h0, timer_pin_oe});
    rd_reg(ADDR_IRQ_STATUS, 8'h00);
    rd_reg(ADDR_CONTROL, 8'h14);
    wait_n(3);
    print_verdict();
  end
endmodule : updown_reload_clockout_timer_tb
